// ==== hdl/dcf_pkg.sv ====
// constants of the dual-clock fifo: geometry, offset defaults, bus map
// assumes a single hclk domain with AHB-Lite register access
package dcf_pkg;
  // ==========================================================
  // geometry (smaller variant: 32,768 words of 18 bits)
  localparam int          DATA_W   = 18;
  localparam int          ADDR_W   = 15;
  localparam int          PTR_W    = 16;
  localparam int          OFF_W    = 15;
  localparam int          SER_W    = 30;
  localparam logic [15:0] DEPTH    = 16'h8000;
  localparam logic [15:0] HALF     = 16'h4000;
  // ==========================================================
  // offset defaults chosen at master reset
  localparam logic [14:0] DEF_OFF_SERIAL   = 15'h03ff;
  localparam logic [14:0] DEF_OFF_PARALLEL = 15'h007f;
  // ==========================================================
  // register map (byte addresses) and fields
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_OFFSETS  = 8'h08;
  localparam int          CTRL_SOFT_RST = 0;
  localparam int          ST_FALL_THROUGH_MODE       = 0;
  localparam int          ST_SERIAL     = 1;
  localparam int          ST_FULL       = 2;
  localparam int          ST_EMPTY      = 3;
  localparam int          ST_COUNT_LSB  = 16;
  localparam int          OFFS_FULL_LSB = 16;
endpackage

// ==== hdl/dual_clock_fifo.sv ====
// dual-clock fifo with standard and fall-through timing, programmable flags
// assumes wclk and rclk are inputs synchronous to hclk, sampled for edges;
// master_reset_n is a synchronous level, hresetn the async power-on reset
//
// Summary of operation
// R1 - mode pin sampled at master reset: low standard, high fall-through
// R2 - standard mode: every word needs read enable low on a read edge
// R3 - fall-through: first word reaches outputs after three read edges unasked
// R4 - write edge with write enable low stores data_in
// R5 - standard: empty flag high after first write, low at last read; empty reads ignored
// R6 - standard: almost-empty low up to n words, high from n+1
// R7 - standard: half-full low above half depth
// R8 - standard: almost-full low from depth minus m words
// R9 - standard: full flag low at depth, blocks writes; a read clears it
// R10 - standard: empty and full flags pass two stages in their own domain
// R11 - fall-through: output-ready low when word valid, high after last read
// R12 - fall-through: almost-empty low up to n+1 words, high from n+2
// R13 - fall-through: half-full low from half depth plus two words
// R14 - fall-through: almost-full low from depth plus one minus m
// R15 - fall-through: input-ready high at depth plus output word, blocks writes
// R16 - fall-through: output-ready three stages, input-ready two stages
// R17 - load select at master reset: high serial 3ff, low parallel 07f defaults
// R18 - offsets read back only by the parallel read sequence; the code also reads them over AHB-Lite at ADDR_OFFSETS
// R19 - offsets may be reprogrammed any time after master reset
// R20 - serial: one bit per write edge, empty lsb first to full msb
// R21 - parallel: write edges load empty then full offset, alternating
// R22 - offset reads alternate empty then full with their own pointer
// R23 - pointers cross between sides through two-stage gray synchronisers
// R24 - master reset clears pointers and sets empty-buffer flags for the mode
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dual_clock_fifo (
  // system
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        master_reset_n,
  // write side
  input  wire logic        wclk,
  input  wire logic        write_enable_n,
  input  wire logic [17:0] data_in,
  input  wire logic        mode_select_serial_input,
  input  wire logic        offset_load_select,
  input  wire logic        serial_shift_enable,
  // read side
  input  wire logic        rclk,
  input  wire logic        read_enable_n,
  output logic      [17:0] data_out,
  // flags, all active low, input_ready_flag included
  output logic             empty_flag,
  output logic             output_ready_flag,
  output logic             full_flag,
  output logic             input_ready_flag,
  output logic             almost_empty_flag,
  output logic             almost_full_flag,
  output logic             half_full_flag,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] bin2gray(input logic [15:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [15:0] gray2bin(input logic [15:0] g);
    logic [15:0] b;
    b = g;
    for (int i = 1; i < 16; i++) begin
      b = b ^ (g >> i);
    end
    return b;
  endfunction

  // count reaches threshold; fall-through thresholds sit one word higher
  function automatic logic reach(input logic [15:0] cnt, input logic [15:0] thr,
                                 input logic fw);
    return cnt >= (thr + {15'h0000, fw});
  endfunction

  // ==========================================================
  // registers
  logic [17:0] mem [0:32767];
  logic        wclk_q_ff, rclk_q_ff;
  logic [15:0] wptr_ff, rptr_ff;
  logic [15:0] wgray_s1_ff, wgray_s2_ff, rgray_s1_ff, rgray_s2_ff;
  logic        ov_ff, ov_s1_ff, ov_s2_ff;
  logic        fall_through_mode_ff, serial_ff;
  logic [14:0] empty_off_ff, full_off_ff;
  logic        wsel_ff, rsel_ff;
  logic        rf_s1_ff, rf_s2_ff, wf_s1_ff;
  logic        soft_rst_ff, wr_pend_ff;
  logic [7:0]  addr_ff;
  logic [17:0] data_out_ff;
  logic        empty_pin_ff, full_pin_ff, pae_ff, paf_ff, hf_ff;
  logic        hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff;

  // ==========================================================
  // decoded events; inputs are taken at the hclk edge where a clock rise shows
  wire logic        mrs      = ~master_reset_n | soft_rst_ff;
  wire logic        w_edge   = wclk & ~wclk_q_ff;
  wire logic        r_edge   = rclk & ~rclk_q_ff;
  wire logic [15:0] w_cnt    = wptr_ff - gray2bin(rgray_s2_ff);
  wire logic [15:0] r_cnt    = gray2bin(wgray_s2_ff) - rptr_ff;
  wire logic        w_full   = (w_cnt == dcf_pkg::DEPTH);
  wire logic        r_empty  = (r_cnt == 16'h0000);
  wire logic [15:0] w_total  = w_cnt + {15'h0000, fall_through_mode_ff & ov_s2_ff};
  wire logic [15:0] r_total  = r_cnt + {15'h0000, fall_through_mode_ff & ov_ff};
  wire logic        w_ok     = w_edge & ~mrs;
  wire logic        r_ok     = r_edge & ~mrs;
  wire logic        wr_mem   = w_ok & offset_load_select & ~write_enable_n & ~w_full;
  wire logic        par_wr   = w_ok & ~offset_load_select & ~write_enable_n & ~serial_ff;
  wire logic        ser_sh   = w_ok & ~offset_load_select & ~serial_shift_enable
                               & write_enable_n & serial_ff;
  wire logic        rd_std   = r_ok & ~fall_through_mode_ff & offset_load_select & ~read_enable_n
                               & ~r_empty;
  wire logic        fw_load  = r_ok & fall_through_mode_ff & offset_load_select & ~r_empty
                               & (~ov_ff | ~read_enable_n);
  wire logic        fw_drop  = r_ok & fall_through_mode_ff & offset_load_select & ov_ff
                               & ~read_enable_n & r_empty;
  wire logic        rd_mem   = rd_std | fw_load;
  wire logic        off_rd   = r_ok & ~offset_load_select & ~read_enable_n;
  wire logic [29:0] offs     = {full_off_ff, empty_off_ff};
  wire logic [14:0] def_off  = offset_load_select ? dcf_pkg::DEF_OFF_SERIAL
                                                  : dcf_pkg::DEF_OFF_PARALLEL;
  wire logic        rf_raw   = fall_through_mode_ff ? ~ov_ff : ~r_empty;
  wire logic        wf_raw   = fall_through_mode_ff ? w_full : ~w_full;

  // ==========================================================
  // clock edge detectors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wclk_q_ff <= 1'b0;
      rclk_q_ff <= 1'b0;
    end else begin
      wclk_q_ff <= wclk;
      rclk_q_ff <= rclk;
    end
  end

  // storage array has no reset; pointers guard every location before use
  always_ff @(posedge hclk) begin
    if (wr_mem) begin
      mem[wptr_ff[14:0]] <= data_in; // R4
    end
  end

  // ==========================================================
  // write side: pointer, mode capture, offset loading
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr_ff   <= 16'h0000;
      fall_through_mode_ff   <= 1'b0;
      serial_ff <= 1'b0;
      wsel_ff   <= 1'b0;
    end else if (mrs) begin
      wptr_ff   <= 16'h0000;                      // R24
      fall_through_mode_ff   <= mode_select_serial_input;      // R1
      serial_ff <= offset_load_select;            // R17
      wsel_ff   <= 1'b0;
    end else begin
      if (wr_mem) begin
        wptr_ff <= wptr_ff + 16'h0001;            // R4
      end
      if (par_wr) begin
        wsel_ff <= ~wsel_ff;                      // R21
      end
    end
  end

  // offsets load by the method chosen at master reset, any time after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      empty_off_ff <= dcf_pkg::DEF_OFF_PARALLEL;
      full_off_ff  <= dcf_pkg::DEF_OFF_PARALLEL;
    end else if (mrs) begin
      empty_off_ff <= def_off;                    // R17
      full_off_ff  <= def_off;
    end else if (ser_sh) begin
      {full_off_ff, empty_off_ff} <= {mode_select_serial_input, offs[29:1]}; // R20 R19
    end else if (par_wr && !wsel_ff) begin
      empty_off_ff <= data_in[14:0];              // R21 R19
    end else if (par_wr) begin
      full_off_ff  <= data_in[14:0];              // R21
    end
  end

  // ==========================================================
  // pointer crossings, each stage advances on its own side's clock rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wgray_s1_ff <= 16'h0000;
      wgray_s2_ff <= 16'h0000;
      rgray_s1_ff <= 16'h0000;
      rgray_s2_ff <= 16'h0000;
      ov_s1_ff    <= 1'b0;
      ov_s2_ff    <= 1'b0;
    end else if (mrs) begin
      wgray_s1_ff <= 16'h0000;
      wgray_s2_ff <= 16'h0000;
      rgray_s1_ff <= 16'h0000;
      rgray_s2_ff <= 16'h0000;
      ov_s1_ff    <= 1'b0;
      ov_s2_ff    <= 1'b0;
    end else begin
      if (r_edge) begin
        wgray_s1_ff <= bin2gray(wptr_ff);         // R23
        wgray_s2_ff <= wgray_s1_ff;
      end
      if (w_edge) begin
        rgray_s1_ff <= bin2gray(rptr_ff);         // R23
        rgray_s2_ff <= rgray_s1_ff;
        ov_s1_ff    <= ov_ff;
        ov_s2_ff    <= ov_s1_ff;
      end
    end
  end

  // ==========================================================
  // read side: pointer, output word, offset readback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rptr_ff     <= 16'h0000;
      ov_ff       <= 1'b0;
      rsel_ff     <= 1'b0;
      data_out_ff <= 18'h00000;
    end else if (mrs) begin
      rptr_ff     <= 16'h0000;                    // R24
      ov_ff       <= 1'b0;
      rsel_ff     <= 1'b0;
      data_out_ff <= 18'h00000;
    end else if (off_rd) begin
      // pin readback only this way (ahb reads them at ADDR_OFFSETS); it overwrites any fall-through word on the outputs
      data_out_ff <= {3'b000, rsel_ff ? full_off_ff : empty_off_ff}; // R22 R18
      rsel_ff     <= ~rsel_ff;                    // R22
    end else if (rd_mem) begin
      data_out_ff <= mem[rptr_ff[14:0]];          // R2 R3
      rptr_ff     <= rptr_ff + 16'h0001;
      ov_ff       <= 1'b1;                        // R3
    end else if (fw_drop) begin
      ov_ff       <= 1'b0;                        // R11
    end
  end

  // ==========================================================
  // empty / output-ready: two stages standard, three fall-through
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rf_s1_ff     <= 1'b0;
      rf_s2_ff     <= 1'b0;
      empty_pin_ff <= 1'b0;
      pae_ff       <= 1'b0;
    end else if (mrs) begin
      rf_s1_ff     <= mode_select_serial_input;   // R24
      rf_s2_ff     <= mode_select_serial_input;
      empty_pin_ff <= mode_select_serial_input;
      pae_ff       <= 1'b0;
    end else if (r_edge) begin
      rf_s1_ff     <= rf_raw;                     // R5 R11
      rf_s2_ff     <= rf_s1_ff;
      empty_pin_ff <= fall_through_mode_ff ? rf_s2_ff : rf_s1_ff; // R10 R16
      pae_ff       <= reach(r_total, {1'b0, empty_off_ff} + 16'h0001, fall_through_mode_ff); // R6 R12
    end
  end

  // full / input-ready two stages; half-full and almost-full on the write side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wf_s1_ff    <= 1'b1;
      full_pin_ff <= 1'b1;
      paf_ff      <= 1'b1;
      hf_ff       <= 1'b1;
    end else if (mrs) begin
      wf_s1_ff    <= ~mode_select_serial_input;   // R24
      full_pin_ff <= ~mode_select_serial_input;
      paf_ff      <= 1'b1;
      hf_ff       <= 1'b1;
    end else if (w_edge) begin
      wf_s1_ff    <= wf_raw;                      // R9 R15
      full_pin_ff <= wf_s1_ff;                    // R10 R16
      paf_ff      <= ~reach(w_total, dcf_pkg::DEPTH - {1'b0, full_off_ff}, fall_through_mode_ff); // R8 R14
      hf_ff       <= ~reach(w_total, dcf_pkg::HALF + 16'h0001, fall_through_mode_ff);            // R7 R13
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  wire logic       addr_ph  = hsel & htrans[1] & hready;
  wire logic [7:0] a_lo     = haddr[7:0];
  wire logic       a_hit    = (haddr[31:8] == 24'h000000);
  wire logic [31:0] st_word = {w_total, 12'h000, r_empty, w_full,
                               serial_ff, fall_through_mode_ff};
  wire logic [31:0] of_word = {1'b0, full_off_ff, 1'b0, empty_off_ff};
  wire logic [31:0] rd_mux  = !a_hit                          ? 32'h00000000 :
                              (a_lo == dcf_pkg::ADDR_STATUS)  ? st_word :
                              (a_lo == dcf_pkg::ADDR_OFFSETS) ? of_word : 32'h00000000;

  // address phase captured; write data applied one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      addr_ff      <= 8'h00;
      hrdata_ff    <= 32'h00000000;
      soft_rst_ff  <= 1'b0;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= addr_ph & hwrite & a_hit;
      addr_ff      <= a_lo;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      if (addr_ph && !hwrite) begin
        hrdata_ff <= rd_mux;
      end
      // soft master reset lasts one cycle; mode pins are sampled in that cycle
      soft_rst_ff <= wr_pend_ff && (addr_ff == dcf_pkg::ADDR_CTRL)
                     && hwdata[dcf_pkg::CTRL_SOFT_RST];
    end
  end

  // ==========================================================
  // outputs
  assign data_out          = data_out_ff;
  assign empty_flag        = empty_pin_ff;
  assign output_ready_flag = empty_pin_ff;
  assign full_flag         = full_pin_ff;
  assign input_ready_flag  = full_pin_ff;
  assign almost_empty_flag = pae_ff;
  assign almost_full_flag  = paf_ff;
  assign half_full_flag    = hf_ff;
  assign hreadyout         = hreadyout_ff;
  assign hresp             = hresp_ff;
  assign hrdata            = hrdata_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence mrs_seq;
    !master_reset_n;
  endsequence

  mode_capture_a: assert property (mrs_seq |=> fall_through_mode_ff == $past(mode_select_serial_input)) // R1
    else $error("timing mode not taken at master reset");
  offset_default_a: assert property (mrs_seq |=> empty_off_ff == (($past(offset_load_select))
    ? dcf_pkg::DEF_OFF_SERIAL : dcf_pkg::DEF_OFF_PARALLEL)) // R17
    else $error("offset default wrong after master reset");
  ptr_clear_a: assert property (mrs_seq |=> wptr_ff == 16'h0000 && rptr_ff == 16'h0000) // R24
    else $error("pointers not cleared by master reset");
  write_store_a: assert property (wr_mem |=> wptr_ff == $past(wptr_ff) + 16'h0001) // R4
    else $error("write did not advance the pointer");
  full_block_a: assert property (w_edge && w_full && !mrs |=> wptr_ff == $past(wptr_ff)) // R9
    else $error("write accepted into a full buffer");
  empty_ignore_a: assert property (r_ok && r_empty && !fall_through_mode_ff |=> rptr_ff == $past(rptr_ff)) // R5
    else $error("read taken from an empty buffer");
  std_read_a: assert property (rd_std |=> rptr_ff == $past(rptr_ff) + 16'h0001) // R2
    else $error("standard read did not advance the pointer");
  par_alt_a: assert property (par_wr && !wsel_ff |=> wsel_ff && empty_off_ff == $past(data_in[14:0])) // R21
    else $error("parallel load did not hit empty offset first");
  serial_shift_a: assert property (ser_sh |=> full_off_ff[14] == $past(mode_select_serial_input)) // R20
    else $error("serial bit not shifted in");
  off_read_a: assert property (off_rd && !rsel_ff |=> data_out_ff[14:0] == $past(empty_off_ff)) // R22
    else $error("offset readback order wrong");
  fw_drop_a: assert property (fw_drop |=> !ov_ff) // R11
    else $error("output word not released");

endmodule

// ==== verification/fifo_stream_partner.sv ====
// far-side model: the writing logic and the reading logic of the fifo
// assumes hclk samples wclk and rclk, so a wclk period spans two hclk edges and an rclk period three
`timescale 1ns/1ps
module fifo_stream_partner (
  // system
  input  wire logic        hclk,
  // write side
  output logic             wclk,
  output logic             write_enable_n,
  output logic      [17:0] data_in,
  output logic             mode_select_serial_input,
  output logic             offset_load_select,
  output logic             serial_shift_enable,
  // read side
  output logic             rclk,
  output logic             read_enable_n,
  input  wire logic [17:0] data_out
);
  // ==========================================================
  // idle levels from time zero: clocks low, every enable off
  initial begin
    wclk                     = 1'b0;
    rclk                     = 1'b0;
    write_enable_n           = 1'b1;
    read_enable_n            = 1'b1;
    serial_shift_enable      = 1'b1;
    offset_load_select       = 1'b1;
    mode_select_serial_input = 1'b0;
    data_in                  = 18'h00000;
  end
  // ==========================================================
  // reset-time straps; the caller holds them through the whole master reset
  task automatic set_cfg(input logic mode, input logic ld);
    @(posedge hclk);
    mode_select_serial_input <= mode;
    offset_load_select       <= ld;
  endtask
  // one write-clock period; controls change after an edge and hold over the rise
  task automatic wtick(input logic wen, input logic ld, input logic sse, input logic si,
                       input logic [17:0] d);
    @(posedge hclk);
    wclk                     <= 1'b0;
    write_enable_n           <= wen;
    offset_load_select       <= ld;
    serial_shift_enable      <= sse;
    mode_select_serial_input <= si;
    data_in                  <= d;
    @(posedge hclk);
    wclk <= 1'b1;
  endtask
  // one read-clock period; the word is taken once the rise has been sampled
  task automatic rtick(input logic ren, input logic ld, output logic [17:0] q);
    @(posedge hclk);
    rclk               <= 1'b0;
    read_enable_n      <= ren;
    offset_load_select <= ld;
    @(posedge hclk);
    rclk <= 1'b1;
    @(posedge hclk);
    #1;
    q = data_out;
  endtask
endmodule

// ==== verification/dual_clock_fifo_flag_logic_test.sv ====
// self-checking bench: standard fill to full, then fall-through with serial offsets
// assumes the partner model drives the fifo pins and the bench speaks ahb-lite
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic_test;
  // ==========================================================
  // signals
  logic        hclk, hresetn, master_reset_n;
  logic        wclk, write_enable_n, mode_select_serial_input, offset_load_select;
  logic        serial_shift_enable, rclk, read_enable_n;
  logic [17:0] data_in, data_out, q, qd;
  logic        empty_flag, full_flag, almost_empty_flag, almost_full_flag, half_full_flag;
  logic        output_ready_flag, input_ready_flag;
  logic        hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [29:0] sv;
  int          fail_count, checks_done, k;
  assign hready = hreadyout; // single slave drives the bus ready
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  dual_clock_fifo dut (.hclk(hclk), .hresetn(hresetn), .master_reset_n(master_reset_n),
    .wclk(wclk), .write_enable_n(write_enable_n), .data_in(data_in),
    .mode_select_serial_input(mode_select_serial_input),
    .offset_load_select(offset_load_select), .serial_shift_enable(serial_shift_enable),
    .rclk(rclk), .read_enable_n(read_enable_n), .data_out(data_out),
    .empty_flag(empty_flag), .output_ready_flag(output_ready_flag), .full_flag(full_flag),
    .input_ready_flag(input_ready_flag), .almost_empty_flag(almost_empty_flag),
    .almost_full_flag(almost_full_flag), .half_full_flag(half_full_flag), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  fifo_stream_partner part (.hclk(hclk), .wclk(wclk), .write_enable_n(write_enable_n),
    .data_in(data_in), .mode_select_serial_input(mode_select_serial_input),
    .offset_load_select(offset_load_select), .serial_shift_enable(serial_shift_enable),
    .rclk(rclk), .read_enable_n(read_enable_n), .data_out(data_out));
  // ==========================================================
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // ahb-lite single word transfer; waits on ready, no fixed latency assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // write until upto words are stored in all; word j carries j+1 so the order can be traced
  task automatic fill(input int upto);
    while (k < upto) begin
      part.wtick(1'b0, 1'b1, 1'b1, 1'b0, 18'(k + 1));
      k++;
    end
  endtask
  // idle periods on both sides let pointers cross and flags settle
  task automatic settle();
    repeat (4) begin
      part.wtick(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
      part.rtick(1'b1, 1'b1, qd);
    end
  endtask
  // ==========================================================
  // watchdog: the fill alone takes about 66k cycles, the whole run under 70k
  initial begin
    #1800000;
    fail_count++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0; master_reset_n = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    fail_count = 0; checks_done = 0; k = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    part.set_cfg(1'b0, 1'b0);
    master_reset_n <= 1'b0;
    repeat (2) @(posedge hclk);
    master_reset_n <= 1'b1;
    @(posedge hclk);
    #1;
    check({empty_flag, full_flag, almost_empty_flag, almost_full_flag, half_full_flag},
          32'h0b);
    ahb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hffff_000f, 32'h0000_0008);
    check(32'(hresp), 32'h0); // slave always answers okay
    ahb(1'b0, dcf_pkg::ADDR_OFFSETS, 32'h0);
    check(rd, 32'h007f_007f);
    ahb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0); // unmapped read gives zero
    part.rtick(1'b0, 1'b1, q);
    check(32'(q), 32'h0);
    // standard mode: parallel offsets n = 2, m = 3, read back alternately
    part.wtick(1'b0, 1'b0, 1'b1, 1'b0, 18'h00002);
    part.wtick(1'b0, 1'b0, 1'b1, 1'b0, 18'h00003);
    part.rtick(1'b0, 1'b0, q);
    check(32'(q), 32'h2);
    part.rtick(1'b0, 1'b0, q);
    check(32'(q), 32'h3);
    ahb(1'b0, dcf_pkg::ADDR_OFFSETS, 32'h0);
    check(rd, 32'h0003_0002);
    fill(1); settle();
    check(32'(empty_flag), 32'h1);
    check(32'(data_out), 32'h3);
    fill(2); settle();
    check(32'(almost_empty_flag), 32'h0);
    fill(3); settle();
    check(32'(almost_empty_flag), 32'h1);
    fill(16384); settle();
    check(32'(half_full_flag), 32'h1);
    fill(16385); settle();
    check(32'(half_full_flag), 32'h0);
    fill(32764); settle();
    check(32'(almost_full_flag), 32'h1);
    fill(32765); settle();
    check(32'(almost_full_flag), 32'h0);
    fill(32767); settle();
    check(32'(full_flag), 32'h1);
    fill(32768); settle();
    check(32'(full_flag), 32'h0);
    part.wtick(1'b0, 1'b1, 1'b1, 1'b0, 18'h3ffff);
    settle();
    ahb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hffff_0004, 32'h8000_0004);
    part.rtick(1'b0, 1'b1, q);
    check(32'(q), 32'h1);
    settle();
    check(32'(full_flag), 32'h1);
    // fall-through mode, serial method, entered by the soft master reset
    part.set_cfg(1'b1, 1'b1);
    ahb(1'b1, dcf_pkg::ADDR_CTRL, 32'h1);
    settle();
    check({empty_flag, full_flag, almost_empty_flag, almost_full_flag, half_full_flag},
          32'h13);
    ahb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hffff_000f, 32'h0000_000b);
    ahb(1'b0, dcf_pkg::ADDR_OFFSETS, 32'h0);
    check(rd, 32'h03ff_03ff);
    sv = {15'd9, 15'd5};
    for (int i = 0; i < 30; i++) part.wtick(1'b1, 1'b0, 1'b0, sv[i], 18'h00000);
    ahb(1'b0, dcf_pkg::ADDR_OFFSETS, 32'h0);
    check(rd, 32'h0009_0005);
    part.rtick(1'b0, 1'b0, q);
    check(32'(q), 32'h5);
    part.rtick(1'b0, 1'b0, q);
    check(32'(q), 32'h9);
    part.wtick(1'b0, 1'b1, 1'b1, 1'b0, 18'h00100);
    part.wtick(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
    repeat (3) part.rtick(1'b1, 1'b1, q);
    check(32'(q), 32'h100);
    repeat (3) part.rtick(1'b1, 1'b1, q);
    check(32'(empty_flag), 32'h0);
    check(32'(output_ready_flag), 32'h0);
    check(32'(input_ready_flag), 32'h0);
    for (int i = 1; i < 6; i++) part.wtick(1'b0, 1'b1, 1'b1, 1'b0, 18'(32'h100 + i));
    settle();
    check(32'(almost_empty_flag), 32'h0);
    part.wtick(1'b0, 1'b1, 1'b1, 1'b0, 18'h00106);
    settle();
    check(32'(almost_empty_flag), 32'h1);
    for (int i = 1; i < 7; i++) begin
      part.rtick(1'b0, 1'b1, q);
      check(32'(q), 32'h100 + i);
    end
    part.rtick(1'b0, 1'b1, q);
    settle();
    check(32'(empty_flag), 32'h1);
    part.rtick(1'b0, 1'b1, qd);
    check(32'(qd), 32'(q));
    print_verdict();
  end
endmodule
